// file: rtl/bms_selector.sv
// boot mode strap selector top: samples four straps once after reset,
// decodes them and launches exactly one boot action
// assumes straps are board pins (asynchronous) and clk_i runs at 125 MHz
`timescale 1ns/10ps
`include "bms_regs.svh"

module bms_selector
  import bms_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // strap pins
  input wire logic strap_flash_select_i,
  input wire logic strap_second_i,
  input wire logic strap_third_i,
  input wire logic strap_fourth_i,
  // pull-up control for strap pads
  output logic strap_flash_pullup_en_o,
  output logic [2:0] strap_other_pullup_en_o,
  // decoded boot action
  output logic mode_valid_o,
  output bms_mode_t mode_o,
  output logic [`BMS_ADDR_W-1:0] branch_addr_o,
  output logic loads_code_o,
  output logic start_o
);
  // ---------------------------------------------------------------
  // pad pull-ups
  // ---------------------------------------------------------------
  // only the first strap has a weak pull-up; the board drives the rest
  // enables are constants: the pad bias never changes after power-up
  assign strap_flash_pullup_en_o = 1'b1;
  assign strap_other_pullup_en_o = 3'h0;

  // ---------------------------------------------------------------
  // strap synchronisers
  // ---------------------------------------------------------------
  // straps are board levels with no relation to clk_i, so each one passes
  // two flops before the sequencer or the decoder looks at it
  logic [3:0] sync1_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_reg;
  logic [3:0] sync2_next;
  wire [3:0] strap_raw = {strap_flash_select_i, strap_second_i, strap_third_i, strap_fourth_i};

  // stage one may go metastable, so nothing but stage two reads it
  // a strap moving near a sample edge resolves to one level or the other
  assign sync1_next = strap_raw;
  assign sync2_next = sync1_reg;

  // first stage; reset low so no strap is claimed before the pins are seen
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= 4'h0;
    end else begin
      sync1_reg <= sync1_next;
    end
  end

  // second stage, the only copy of the pins that the rest of the block uses
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync2_reg <= 4'h0;
    end else begin
      sync2_reg <= sync2_next;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // timeline after release: the settle count, one edge to capture the
  // straps, one edge to launch; start_o is high after the launch edge
  bms_state_t state_reg;
  bms_state_t state_next;
  logic [`BMS_CNT_W-1:0] settle_reg;
  logic [`BMS_CNT_W-1:0] settle_next;
  logic [`BMS_CNT_W-1:0] settle_last;
  // straps_reg is the only copy of the straps that the decoder sees
  logic [3:0] straps_reg;
  logic [3:0] straps_next;

  // one named wire per state keeps the register updates short
  wire in_settle = (state_reg == BMS_ST_SETTLE);
  wire in_sample = (state_reg == BMS_ST_SAMPLE);
  wire in_launch = (state_reg == BMS_ST_LAUNCH);

  // settle lets the synchronisers fill with real pin levels first; the
  // count is fixed, so the boot action always starts at the same cycle
  assign settle_last = `BMS_CNT_W'(`BMS_SETTLE_CYC - 1);
  wire settle_done = (settle_reg == settle_last);

  // the counter only runs while settling, so it can never wrap and relaunch
  assign settle_next = (in_settle && !settle_done) ?
                       settle_reg + `BMS_CNT_W'(1) : settle_reg;

  // sampled straps travel to the decoder on the carrier
  bms_dec_if dec_if ();
  assign dec_if.straps = straps_reg;

  // decoder is combinational; its result is read in the launch state only
  bms_decode u_decode (
    .dec (dec_if.dec)
  );

  // one pass through the states per reset; hold is never left
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BMS_ST_SETTLE: begin
        if (settle_done) begin
          state_next = BMS_ST_SAMPLE;
        end
      end
      BMS_ST_SAMPLE: begin
        state_next = BMS_ST_LAUNCH;
      end
      BMS_ST_LAUNCH: begin
        state_next = BMS_ST_HOLD;
      end
      BMS_ST_HOLD: begin
        state_next = BMS_ST_HOLD;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= BMS_ST_SETTLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // settle counter, restarted by every reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settle_reg <= '0;
    end else begin
      settle_reg <= settle_next;
    end
  end

  // capture straps exactly once per reset; later pin changes are ignored
  assign straps_next = in_sample ? sync2_reg : straps_reg;

  // captured straps, cleared by reset so no stale pattern outlives it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      straps_reg <= 4'h0;
    end else begin
      straps_reg <= straps_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, registered and frozen after launch
  // ---------------------------------------------------------------
  // next values, one per output register
  logic start_next;
  logic mode_valid_next;
  bms_mode_t mode_next;
  logic [`BMS_ADDR_W-1:0] branch_addr_next;
  logic loads_code_next;

  // the decoder is read only in the launch cycle; outside it each output
  // except start_o keeps its value, so a strap change after capture can never show
  assign start_next = in_launch;
  assign mode_valid_next = in_launch || mode_valid_o;
  assign mode_next = in_launch ? dec_if.mode : mode_o;
  assign branch_addr_next = in_launch ? dec_if.target : branch_addr_o;
  assign loads_code_next = in_launch ? dec_if.loads_code : loads_code_o;

  // launch strobe, high for exactly one cycle per reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_o <= 1'b0;
    end else begin
      start_o <= start_next;
    end
  end

  // valid flag, high from launch until the next reset; there is no abort,
  // so a new strap pattern needs a new reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_valid_o <= 1'b0;
    end else begin
      mode_valid_o <= mode_valid_next;
    end
  end

  // decoded action; reset shows the parallel loader with no target, but
  // valid is low then, so nothing downstream may act on it yet
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_o <= BMS_MODE_PARALLEL;
      branch_addr_o <= '0;
      loads_code_o <= 1'b0;
    end else begin
      mode_o <= mode_next;
      branch_addr_o <= branch_addr_next;
      loads_code_o <= loads_code_next;
    end
  end
endmodule

// file: pkg/bms_regs.svh
// constants for the boot mode strap selector: target addresses and timing
// assumes inclusion by bare name from package and rtl files
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH

// branch targets (22-bit program address)
`define BMS_ADDR_W 22
`define BMS_FLASH_ENTRY 22'h3f7ff6
`define BMS_RAM_ENTRY 22'h3f8000
`define BMS_OTP_FIRST 22'h3d7800
`define BMS_OTP_LAST 22'h3d7bff

// strap positions within the sampled vector
`define BMS_STRAP_FLASH 3
`define BMS_STRAP_SECOND 2
`define BMS_STRAP_THIRD 1
`define BMS_STRAP_FOURTH 0

// settle time of straps after reset release, in ns, and cycles at 125 MHz
`define BMS_SETTLE_NS 64
`define BMS_CLK_PERIOD_NS 8
`define BMS_SETTLE_CYC ((`BMS_SETTLE_NS + `BMS_CLK_PERIOD_NS - 1) / `BMS_CLK_PERIOD_NS)
`define BMS_CNT_W 4

`endif

// file: pkg/bms_pkg.sv
// types for the boot mode strap selector
// assumes bms_regs.svh is on the include path
package bms_pkg;
  `include "bms_regs.svh"

  // boot actions, one-hot
  typedef enum logic [5:0] {
    BMS_MODE_FLASH = 6'h01,
    BMS_MODE_SPI = 6'h02,
    BMS_MODE_ASYNC = 6'h04,
    BMS_MODE_RAM = 6'h08,
    BMS_MODE_OTP = 6'h10,
    BMS_MODE_PARALLEL = 6'h20
  } bms_mode_t;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    BMS_ST_SETTLE = 4'h1,
    BMS_ST_SAMPLE = 4'h2,
    BMS_ST_LAUNCH = 4'h4,
    BMS_ST_HOLD = 4'h8
  } bms_state_t;
endpackage

// file: pkg/bms_dec_if.sv
// carries the sampled strap vector to the decoder and the decoded action back
// assumes one clock domain; decoder is purely combinational
`timescale 1ns/10ps
`include "bms_regs.svh"
interface bms_dec_if;
  import bms_pkg::*;
  logic [3:0] straps;
  bms_mode_t mode;
  logic [`BMS_ADDR_W-1:0] target;
  logic loads_code;
  modport seq (output straps, input mode, input target, input loads_code);
  modport dec (input straps, output mode, output target, output loads_code);
endinterface

// file: rtl/bms_decode.sv
// strap pattern decoder: maps four strap levels to a boot action and target
// assumes straps are stable, already captured by the sequencer
`timescale 1ns/10ps
`include "bms_regs.svh"
module bms_decode
  import bms_pkg::*;
(
  // decoder side of the carrier
  bms_dec_if.dec dec
);
  // ---------------------------------------------------------------
  // pattern match, first strap has priority over all others
  // ---------------------------------------------------------------
  wire s_flash = dec.straps[`BMS_STRAP_FLASH];
  wire s_second = dec.straps[`BMS_STRAP_SECOND];
  wire [1:0] s_low = {dec.straps[`BMS_STRAP_THIRD], dec.straps[`BMS_STRAP_FOURTH]};
  wire hit_flash = s_flash;
  wire hit_spi = !s_flash && s_second;
  wire hit_async = !s_flash && !s_second && (s_low == 2'h3);
  wire hit_ram = !s_flash && !s_second && (s_low == 2'h2);
  wire hit_otp = !s_flash && !s_second && (s_low == 2'h1);

  // selection of action; all-zero pattern falls to parallel port
  assign dec.mode = hit_flash ? BMS_MODE_FLASH :
                    hit_spi ? BMS_MODE_SPI :
                    hit_async ? BMS_MODE_ASYNC :
                    hit_ram ? BMS_MODE_RAM :
                    hit_otp ? BMS_MODE_OTP :
                    BMS_MODE_PARALLEL;

  // branch target; otp entry is the base of its 1k-word window
  assign dec.target = hit_flash ? `BMS_FLASH_ENTRY :
                      hit_ram ? `BMS_RAM_ENTRY :
                      hit_otp ? `BMS_OTP_FIRST :
                      {`BMS_ADDR_W{1'b0}};

  // branch modes load nothing from outside
  assign dec.loads_code = !(hit_flash || hit_ram || hit_otp);
endmodule

// file: tb/bms_strap_board.sv
// board model driving the four strap pins of the selector
// assumes the bench says which straps it drives; released pins float
`timescale 1ns/10ps
module bms_strap_board (
  // bench control
  input wire logic clk_i,
  input wire logic [3:0] level_i,
  input wire logic [3:0] drive_i,
  // pad pull-up from the selector
  input wire logic pullup_en_i,
  // levels seen at the pins
  output logic [3:0] pins_o
);
  // a floating pin wanders, so it never offers a steady level by luck
  logic wander_reg = 1'b0;
  always @(posedge clk_i) begin
    wander_reg <= !wander_reg;
  end
  // first strap falls back to its pull-up, the rest must be driven
  assign pins_o[3] = drive_i[3] ? level_i[3] : (pullup_en_i | wander_reg);
  assign pins_o[2:0] = (level_i[2:0] & drive_i[2:0]) | ({3{wander_reg}} & ~drive_i[2:0]);
  // boot code at the flash entry and loads on the clock pin are taken as ready
endmodule

// file: tb/bms_selector_props.sv
// assertions on the strap selector top ports
// assumes bms_pkg is compiled first; one clock domain
`timescale 1ns/10ps
`include "bms_regs.svh"
module bms_selector_props
  import bms_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // straps and selector outputs
  input wire logic strap_flash_select_i,
  input wire logic strap_second_i,
  input wire logic strap_flash_pullup_en_o,
  input wire logic [2:0] strap_other_pullup_en_o,
  input wire logic mode_valid_o,
  input wire bms_mode_t mode_o,
  input wire logic [`BMS_ADDR_W-1:0] branch_addr_o,
  input wire logic loads_code_o,
  input wire logic start_o
);
  // cycles since release; saturates so it never comes back to the launch count
  logic [3:0] since_rel_reg;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      since_rel_reg <= 4'h0;
    else if (since_rel_reg != 4'hf)
      since_rel_reg <= since_rel_reg + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  pullup_fixed_a: assert property (strap_flash_pullup_en_o && strap_other_pullup_en_o == 3'h0)
    else $error("strap pull-up enables wrong");
  launch_time_a: assert property ((since_rel_reg == 4'(`BMS_SETTLE_CYC + 2)) == start_o)
    else $error("launch pulse at wrong cycle");
  valid_pulse_a: assert property ($rose(mode_valid_o) |-> start_o ##1 !start_o)
    else $error("valid rose without one-cycle launch");
  mode_held_a: assert property (mode_valid_o |=> mode_valid_o && $stable(mode_o)
    && $stable(branch_addr_o) && $stable(loads_code_o)) else $error("launched action moved");
  flash_pick_a: assert property (start_o && $past(strap_flash_select_i, 4)
    |-> mode_o == BMS_MODE_FLASH) else $error("flash strap not obeyed");
  spi_pick_a: assert property (start_o && !$past(strap_flash_select_i, 4)
    && $past(strap_second_i, 4) |-> mode_o == BMS_MODE_SPI) else $error("spi strap not obeyed");
  flash_addr_a: assert property (mode_valid_o && mode_o == BMS_MODE_FLASH
    |-> branch_addr_o == `BMS_FLASH_ENTRY && !loads_code_o) else $error("flash target wrong");
  ram_addr_a: assert property (mode_valid_o && mode_o == BMS_MODE_RAM
    |-> branch_addr_o == `BMS_RAM_ENTRY && !loads_code_o) else $error("ram target wrong");
  otp_addr_a: assert property (mode_valid_o && mode_o == BMS_MODE_OTP
    |-> branch_addr_o == `BMS_OTP_FIRST && !loads_code_o) else $error("otp target wrong");
  loader_flag_a: assert property (mode_valid_o && mode_o inside {BMS_MODE_SPI,
    BMS_MODE_ASYNC, BMS_MODE_PARALLEL} |-> loads_code_o) else $error("loader flag low");
  cover property (start_o && mode_o == BMS_MODE_FLASH);
  cover property (start_o && mode_o == BMS_MODE_OTP);
  cover property (start_o && mode_o == BMS_MODE_PARALLEL);
endmodule
bind bms_selector bms_selector_props u_props (.clk_i, .arst_n_i, .strap_flash_select_i,
  .strap_second_i, .strap_flash_pullup_en_o, .strap_other_pullup_en_o, .mode_valid_o,
  .mode_o, .branch_addr_o, .loads_code_o, .start_o);

// file: tb/bms_selector_bench.sv
// self-checking bench: one reset per strap pattern, then straps are flipped
// assumes the board model and checker are compiled before this file
`timescale 1ns/10ps
`include "bms_regs.svh"
module bms_selector_bench
  import bms_pkg::*;
  ;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] drv = 4'hf;
  logic [3:0] pins;
  logic pu1;
  logic [2:0] pu_oth;
  logic vld;
  logic ld;
  logic st;
  bms_mode_t mode;
  logic [`BMS_ADDR_W-1:0] addr;
  int n_mismatch = 0;
  int checks_done = 0;
  // 125 MHz clock
  always #4 clk_i = !clk_i;
  bms_strap_board board (.clk_i(clk_i), .level_i(lvl), .drive_i(drv), .pullup_en_i(pu1),
    .pins_o(pins));
  bms_selector uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .strap_flash_select_i(pins[3]),
    .strap_second_i(pins[2]), .strap_third_i(pins[1]), .strap_fourth_i(pins[0]),
    .strap_flash_pullup_en_o(pu1), .strap_other_pullup_en_o(pu_oth), .mode_valid_o(vld),
    .mode_o(mode), .branch_addr_o(addr), .loads_code_o(ld), .start_o(st));
  // shared compare for every result, counting each check
  task automatic cmp(input string what, input logic [21:0] exp, input logic [21:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reset 3 cycles on given straps, wait for launch, then flip straps and
  // confirm the launched action stays put until the next reset
  task automatic boot(input logic [3:0] l, input logic [3:0] d, input bms_mode_t m,
    input logic [21:0] a, input logic lc);
    int n;
    @(negedge clk_i);
    lvl = l;
    drv = d;
    arst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    n = 0;
    while (st !== 1'b1 && n < 30) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 30) begin
      n_mismatch++;
      stop_test();
    end
    cmp("launch cycle", 22'(`BMS_SETTLE_CYC + 2), 22'(n));
    cmp("valid", 22'h1, 22'(vld));
    cmp("pull-ups", 22'h8, 22'({pu1, pu_oth}));
    cmp("mode", 22'(m), 22'(mode));
    cmp("target", a, addr);
    cmp("loads", 22'(lc), 22'(ld));
    lvl = ~l;
    drv = 4'hf;
    repeat (20) @(negedge clk_i);
    cmp("held mode", 22'(m), 22'(mode));
    cmp("held start", 22'h0, 22'(st));
    cmp("held target", a, addr);
    cmp("held valid", 22'h1, 22'(vld));
  endtask
  // first strap released or driven high: others must not matter
  task automatic t_flash();
    boot(4'h6, 4'h7, BMS_MODE_FLASH, `BMS_FLASH_ENTRY, 1'b0);
    boot(4'h8, 4'hf, BMS_MODE_FLASH, `BMS_FLASH_ENTRY, 1'b0);
  endtask
  task automatic t_spi();
    boot(4'h4, 4'hf, BMS_MODE_SPI, 22'h0, 1'b1);
    boot(4'h7, 4'hf, BMS_MODE_SPI, 22'h0, 1'b1);
  endtask
  task automatic t_async();
    boot(4'h3, 4'hf, BMS_MODE_ASYNC, 22'h0, 1'b1);
  endtask
  task automatic t_ram();
    boot(4'h2, 4'hf, BMS_MODE_RAM, `BMS_RAM_ENTRY, 1'b0);
  endtask
  task automatic t_otp();
    boot(4'h1, 4'hf, BMS_MODE_OTP, `BMS_OTP_FIRST, 1'b0);
  endtask
  task automatic t_par();
    boot(4'h0, 4'hf, BMS_MODE_PARALLEL, 22'h0, 1'b1);
  endtask
  initial begin
    t_flash();
    t_spi();
    t_async();
    t_ram();
    t_otp();
    t_par();
    stop_test();
  end
endmodule
